/* verilog/sbsd_core.sv */
// Purpose: execute unit for subtract-with-borrow (to accumulator or memory) and decrement-skip-zero
// Assumes: one-cycle data memory read port, data valid the cycle after mem_rd_o
// Notes:   instructions arrive on a valid/ready strobe or through the wishbone control register
//
// Behaviour
// - sub_borrow_to_acc puts accumulator minus memory minus inverted carry into the accumulator and sets the four flags.
// - After either subtract the carry flag is cleared when the result went negative.
// - After either subtract the carry flag is set when the result is positive or zero.
// - sub_borrow_to_mem computes the same difference and writes it to the addressed memory byte, setting the four flags.
// - dec_skip_zero lowers the memory byte by one and skips the next instruction when the result is zero.
// - A skip adds a dummy cycle, so the instruction takes two instruction cycles.
// - A nonzero decrement result lets the next sequential instruction run as normal.
`timescale 1ns/1ps
`default_nettype none
module sbsd_core
  import sbsd_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // instruction strobe
  input  wire logic             op_valid_i,
  input  wire logic [1:0]       op_i,
  input  wire logic [7:0]       op_addr_i,
  output logic                  op_ready_o,
  output logic                  done_o,
  output logic                  skip_o,
  // data memory port
  output logic                  mem_rd_o,
  output logic                  mem_wr_o,
  output logic [7:0]            mem_addr_o,
  output logic [7:0]            mem_wdata_o,
  input  wire logic [7:0]       mem_rdata_i,
  // architectural state
  output logic [7:0]            accumulator_o,
  output sbsd_flags_t           flags_o,
  // wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [WB_AW-1:0] wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  input  wire logic [3:0]       wb_sel_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  wb_err_o
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_READ = 2'b01,
    S_EXEC = 2'b11,
    S_SKIP = 2'b10
  } sbsd_state_t;

  sbsd_state_t   state_reg, state_next;
  logic [7:0]    acc_reg;
  sbsd_flags_t   flags_reg;
  logic [1:0]    op_reg;
  logic [7:0]    addr_reg;
  logic [7:0]    wdata_reg;
  logic          wr_reg;
  logic          done_reg;
  logic          skip_reg;
  logic          ack_reg;
  logic [31:0]   rdat_reg;
  logic          sw_go_reg;
  logic [1:0]    sw_op_reg;
  logic [7:0]    sw_addr_reg;
  logic          last_skip_reg;

  sbsd_alu_out_t sub_res;
  logic [7:0]    dec_res;

  sbsd_alu u_alu (
    .a_i     (acc_reg),
    .b_i     (mem_rdata_i),
    .carry_i (flags_reg.carry_flag),
    .sub_o   (sub_res),
    .dec_o   (dec_res)
  );

  // wishbone decode
  wire logic wb_req     = wb_cyc_i & wb_stb_i & ~ack_reg & ~wb_err_o;
  wire logic adr_ctrl   = (wb_adr_i == REG_CTRL);
  wire logic adr_acc    = (wb_adr_i == REG_ACC);
  wire logic adr_flags  = (wb_adr_i == REG_FLAGS);
  wire logic adr_stat   = (wb_adr_i == REG_STATUS);
  wire logic adr_ok     = adr_ctrl | adr_acc | adr_flags | adr_stat;
  // writes land at the edge where the master samples ack
  wire logic wb_wr      = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & adr_ok;
  wire logic idle       = (state_reg == S_IDLE);
  wire logic ctrl_wr    = wb_wr & adr_ctrl & wb_sel_i[1] & wb_dat_i[CTRL_GO];
  wire logic acc_wr     = wb_wr & adr_acc & wb_sel_i[0] & idle;
  wire logic flags_wr   = wb_wr & adr_flags & wb_sel_i[0] & idle;
  logic      wb_err_reg;
  assign wb_err_o = wb_err_reg;

  // instruction source: hardware strobe wins over software go
  wire logic       hw_take = op_valid_i & idle;
  wire logic       sw_take = sw_go_reg & idle & ~op_valid_i;
  wire logic       take    = hw_take | sw_take;
  wire logic [1:0] take_op = hw_take ? op_i : sw_op_reg;
  wire logic [7:0] take_ad = hw_take ? op_addr_i : sw_addr_reg;
  wire logic       dec_zero = (dec_res == 8'h00);

  wire logic [31:0] rd_mux =
    adr_ctrl  ? {16'h0000, sw_go_reg, 5'h00, sw_op_reg, sw_addr_reg} :
    adr_acc   ? {24'h000000, acc_reg} :
    adr_flags ? {28'h0000000, flags_reg} :
                {29'h0000000, last_skip_reg, ~idle, done_reg};

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: if (take) state_next = S_READ;
      S_READ: state_next = S_EXEC;
      S_EXEC: state_next = (op_reg == SBSD_OP_DEC_SKIP && dec_zero) ? S_SKIP : S_IDLE;
      S_SKIP: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg     <= S_IDLE;
      op_reg        <= SBSD_OP_NONE;
      addr_reg      <= 8'h00;
      wr_reg        <= 1'b0;
      wdata_reg     <= 8'h00;
      done_reg      <= 1'b0;
      skip_reg      <= 1'b0;
      last_skip_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      wr_reg    <= 1'b0;
      done_reg  <= 1'b0;
      skip_reg  <= 1'b0;
      if (take)
      begin
        op_reg   <= take_op;
        addr_reg <= take_ad;
      end
      if (state_reg == S_EXEC)
      begin
        unique case (op_reg)
          SBSD_OP_SUB_MEM:
          begin
            wr_reg    <= 1'b1;
            wdata_reg <= sub_res.result;
          end
          SBSD_OP_DEC_SKIP:
          begin
            wr_reg    <= 1'b1;
            wdata_reg <= dec_res;
          end
          default: wr_reg <= 1'b0;
        endcase
        skip_reg      <= (op_reg == SBSD_OP_DEC_SKIP) & dec_zero;
        last_skip_reg <= (op_reg == SBSD_OP_DEC_SKIP) & dec_zero;
        done_reg      <= ~((op_reg == SBSD_OP_DEC_SKIP) & dec_zero);
      end
      if (state_reg == S_SKIP)
        done_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_reg   <= ACC_RST;
      flags_reg <= FLAGS_RST;
    end
    else if (state_reg == S_EXEC && op_reg != SBSD_OP_DEC_SKIP && op_reg != SBSD_OP_NONE)
    begin
      flags_reg <= sub_res.flags;
      if (op_reg == SBSD_OP_SUB_ACC)
        acc_reg <= sub_res.result;
    end
    else
    begin
      if (acc_wr)
        acc_reg <= wb_dat_i[7:0];
      if (flags_wr)
        flags_reg <= wb_dat_i[3:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg     <= 1'b0;
      wb_err_reg  <= 1'b0;
      rdat_reg    <= 32'h00000000;
      sw_go_reg   <= 1'b0;
      sw_op_reg   <= SBSD_OP_NONE;
      sw_addr_reg <= 8'h00;
    end
    else
    begin
      ack_reg    <= wb_req & adr_ok;
      wb_err_reg <= wb_req & ~adr_ok;
      if (wb_req)
        rdat_reg <= rd_mux;
      if (sw_take)
        sw_go_reg <= 1'b0;
      if (wb_wr & adr_ctrl)
      begin
        if (wb_sel_i[0])
          sw_addr_reg <= wb_dat_i[CTRL_ADDR_LSB +: 8];
        if (wb_sel_i[1])
          sw_op_reg <= wb_dat_i[CTRL_OP_LSB +: 2];
        if (ctrl_wr)
          sw_go_reg <= 1'b1;
      end
    end
  end

  assign op_ready_o    = idle;
  assign done_o        = done_reg;
  assign skip_o        = skip_reg;
  assign mem_rd_o      = (state_reg == S_READ);
  assign mem_wr_o      = wr_reg;
  assign mem_addr_o    = addr_reg;
  assign mem_wdata_o   = wdata_reg;
  assign accumulator_o = acc_reg;
  assign flags_o       = flags_reg;
  assign wb_ack_o      = ack_reg;
  assign wb_dat_o      = rdat_reg;

  property p_dec_flags;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == S_EXEC && op_reg == SBSD_OP_DEC_SKIP) |=> $stable(flags_reg);
  endproperty
  a_dec_flags: assert property (p_dec_flags) else $error("decrement changed flags");

  property p_dec_wr;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == S_EXEC && op_reg == SBSD_OP_DEC_SKIP)
      |=> mem_wr_o && mem_wdata_o == $past(mem_rdata_i) - ONE8;
  endproperty
  a_dec_wr: assert property (p_dec_wr) else $error("decrement not written back");

  sequence s_skip_exec;
    state_reg == S_EXEC && op_reg == SBSD_OP_DEC_SKIP && dec_zero;
  endsequence
  property p_skip_two;
    @(posedge clk_i) disable iff (rst_i)
    s_skip_exec |=> skip_o && !done_o && !op_ready_o ##1 done_o && op_ready_o;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("skip timing wrong");

  property p_no_skip;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == S_EXEC && op_reg == SBSD_OP_DEC_SKIP && !dec_zero) |=> !skip_o && done_o && op_ready_o;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("nonzero decrement skipped");

  property p_sub_acc;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == S_EXEC && op_reg == SBSD_OP_SUB_ACC)
      |=> accumulator_o == $past(acc_reg) - $past(mem_rdata_i) - {7'h00, ~$past(flags_reg.carry_flag)};
  endproperty
  a_sub_acc: assert property (p_sub_acc) else $error("accumulator difference wrong");

  property p_carry_clr;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == S_EXEC && (op_reg == SBSD_OP_SUB_ACC || op_reg == SBSD_OP_SUB_MEM)
      && ({1'b0, acc_reg} < {1'b0, mem_rdata_i} + {8'h00, ~flags_reg.carry_flag})) |=> !flags_o.carry_flag;
  endproperty
  a_carry_clr: assert property (p_carry_clr) else $error("carry not cleared on borrow");

  property p_carry_set;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == S_EXEC && (op_reg == SBSD_OP_SUB_ACC || op_reg == SBSD_OP_SUB_MEM)
      && ({1'b0, acc_reg} >= {1'b0, mem_rdata_i} + {8'h00, ~flags_reg.carry_flag})) |=> flags_o.carry_flag;
  endproperty
  a_carry_set: assert property (p_carry_set) else $error("carry not set");

  property p_sub_mem;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == S_EXEC && op_reg == SBSD_OP_SUB_MEM)
      |=> mem_wr_o && $stable(accumulator_o) && mem_wdata_o == $past(sub_res.result);
  endproperty
  a_sub_mem: assert property (p_sub_mem) else $error("memory difference wrong");

  property p_zero_flag;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == S_EXEC && op_reg == SBSD_OP_SUB_ACC) |=> flags_o.zero_flag == (accumulator_o == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag disagrees with accumulator");

  property p_zero_mem;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == S_EXEC && op_reg == SBSD_OP_SUB_MEM) |=> flags_o.zero_flag == (mem_wdata_o == 8'h00);
  endproperty
  a_zero_mem: assert property (p_zero_mem) else $error("zero flag disagrees with memory result");

  property p_half_carry;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == S_EXEC && (op_reg == SBSD_OP_SUB_ACC || op_reg == SBSD_OP_SUB_MEM))
      |=> flags_o.half_carry_flag
          == ($past({1'b0, acc_reg[3:0]}) >= $past({1'b0, mem_rdata_i[3:0]}) + {4'h0, ~$past(flags_reg.carry_flag)});
  endproperty
  a_half_carry: assert property (p_half_carry) else $error("half carry wrong");

  property p_acc_no_mem;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == S_EXEC && op_reg == SBSD_OP_SUB_ACC) |=> !mem_wr_o;
  endproperty
  a_acc_no_mem: assert property (p_acc_no_mem) else $error("accumulator subtract wrote memory");
endmodule
`default_nettype wire

/* verilog/sbsd_pkg.sv */
// Purpose: shared constants and types for the subtract-borrow / decrement-skip datapath
// Assumes: 8-bit data, Wishbone classic register port
// Notes:   register indices are byte addresses (multiples of four)
package sbsd_pkg;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned WB_AW    = 4;
  // wishbone register byte offsets
  localparam logic [WB_AW-1:0] REG_CTRL   = 4'h0;
  localparam logic [WB_AW-1:0] REG_ACC    = 4'h4;
  localparam logic [WB_AW-1:0] REG_FLAGS  = 4'h8;
  localparam logic [WB_AW-1:0] REG_STATUS = 4'hc;
  // flag bit positions in REG_FLAGS
  localparam int unsigned FLG_C  = 0;
  localparam int unsigned FLG_AC = 1;
  localparam int unsigned FLG_Z  = 2;
  localparam int unsigned FLG_OV = 3;
  // control fields
  localparam int unsigned CTRL_GO     = 15;
  localparam int unsigned CTRL_OP_LSB = 8;
  localparam int unsigned CTRL_ADDR_LSB = 0;
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [7:0] ONE8      = 8'h01;

  typedef enum logic [1:0] {
    SBSD_OP_SUB_ACC  = 2'h0,
    SBSD_OP_SUB_MEM  = 2'h1,
    SBSD_OP_DEC_SKIP = 2'h2,
    SBSD_OP_NONE     = 2'h3
  } sbsd_op_t;

  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } sbsd_flags_t;

  typedef struct packed {
    logic [7:0]  result;
    sbsd_flags_t flags;
  } sbsd_alu_out_t;
endpackage

/* verilog/sbsd_alu.sv */
// Purpose: combinational subtract-with-borrow and decrement
// Assumes: carry flag set means no borrow pending
// Notes:   pure logic, no state
`timescale 1ns/1ps
`default_nettype none
module sbsd_alu
  import sbsd_pkg::*;
(
  input  wire logic [7:0]    a_i,
  input  wire logic [7:0]    b_i,
  input  wire logic          carry_i,
  output sbsd_alu_out_t      sub_o,
  output logic [7:0]         dec_o
);
  wire logic       borrow_in = ~carry_i;
  wire logic [8:0] full      = {1'b0, a_i} - {1'b0, b_i} - {8'h00, borrow_in};
  wire logic [4:0] low       = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, borrow_in};

  assign sub_o.result                = full[7:0];
  // carry set when no borrow
  assign sub_o.flags.carry_flag      = ~full[8];
  assign sub_o.flags.half_carry_flag = ~low[4];
  assign sub_o.flags.zero_flag       = (full[7:0] == 8'h00);
  assign sub_o.flags.overflow_flag   = (a_i[7] ^ b_i[7]) & (a_i[7] ^ full[7]);
  assign dec_o                       = b_i - ONE8;
endmodule
`default_nettype wire

/* tb/subtract_borrow_skip_decrement_test.sv */
// Purpose: self-checking bench for the subtract-borrow / decrement-skip core
// Assumes: bench plays the data memory, read data one cycle after the read strobe
// Notes:   random operands from a fixed seed, compared with a bench model
`timescale 1ns/1ps
`default_nettype none
module subtract_borrow_skip_decrement_test;
  import sbsd_pkg::*;
  logic             clk_i       = 1'b0;
  logic             rst_i       = 1'b1;
  logic             op_valid_i  = 1'b0;
  logic [1:0]       op_i        = 2'h0;
  logic [7:0]       op_addr_i   = 8'h00;
  logic [7:0]       mem_rdata_i = 8'h00;
  logic             wb_cyc_i    = 1'b0;
  logic             wb_stb_i    = 1'b0;
  logic             wb_we_i     = 1'b0;
  logic [WB_AW-1:0] wb_adr_i    = 4'h0;
  logic [31:0]      wb_dat_i    = 32'h0;
  logic [3:0]       wb_sel_i    = 4'h0;
  logic             op_ready_o, done_o, skip_o, mem_rd_o, mem_wr_o, wb_ack_o, wb_err_o;
  logic [7:0]       mem_addr_o, mem_wdata_o, accumulator_o;
  logic [31:0]      wb_dat_o;
  sbsd_flags_t      flags_o;
  logic [7:0]       mem [256];
  int               n_errors = 0;
  int               comparisons = 0;
  int               cyc_cnt = 0;
  int               acc_m, flg_m, lat, skip_at;

  sbsd_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .op_addr_i(op_addr_i), .op_ready_o(op_ready_o), .done_o(done_o), .skip_o(skip_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .accumulator_o(accumulator_o), .flags_o(flags_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o));

  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  // data memory; read data toggles when no read is pending
  always @(posedge clk_i)
  begin
    if (mem_wr_o)
      mem[mem_addr_o] <= mem_wdata_o;
    mem_rdata_i <= mem_rd_o ? mem[mem_addr_o] : ~mem_rdata_i;
  end

  always @(posedge clk_i)
  begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 5000)
    begin
      n_errors = n_errors + 1;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [WB_AW-1:0] adr, input logic [31:0] dat,
                         output logic [31:0] rd, output logic er);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
      @(posedge clk_i);
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  // counts edges after the take until done, noting where skip was seen
  task automatic run_op(input logic [1:0] op, input logic [7:0] adr);
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_i       <= op;
    op_addr_i  <= adr;
    @(posedge clk_i);
    while (op_ready_o !== 1'b1)
      @(posedge clk_i);
    op_valid_i <= 1'b0;
    lat = 0;
    skip_at = 0;
    while (done_o !== 1'b1)
    begin
      @(posedge clk_i);
      lat = lat + 1;
      if (skip_o === 1'b1)
        skip_at = lat;
    end
  endtask

  task automatic exec_check(input logic [1:0] op, input logic [7:0] adr, input logic sw);
    int          a, b, bw, d, sa, sb, sd, r, mexp, ov;
    logic [31:0] rd;
    logic        er;
    a = acc_m;
    b = mem[adr];
    bw = flg_m[0] ? 0 : 1;
    d = a - b - bw;
    sa = a - (a[7] ? 256 : 0);
    sb = b - (b[7] ? 256 : 0);
    sd = sa - sb - bw;
    ov = (sd < -128 || sd > 127) ? 1 : 0;
    r = (op == SBSD_OP_DEC_SKIP) ? ((b - 1) & 255) : (d & 255);
    mexp = (op == SBSD_OP_SUB_MEM || op == SBSD_OP_DEC_SKIP) ? r : b;
    if (op == SBSD_OP_SUB_ACC || op == SBSD_OP_SUB_MEM)
      flg_m = (ov << 3) | ((r == 0) << 2) | ((((a & 15) - (b & 15) - bw) >= 0) << 1) | (d >= 0);
    if (op == SBSD_OP_SUB_ACC)
      acc_m = r;
    if (sw)
    begin
      wb_xfer(1'b1, REG_CTRL, 32'h8000 | (32'(op) << 8) | 32'(adr), rd, er);
      while (done_o !== 1'b1)
        @(posedge clk_i);
    end
    else
    begin
      run_op(op, adr);
      check("skip_at", skip_at, (op == SBSD_OP_DEC_SKIP && r == 0) ? 3 : 0);
      check("latency", lat, (op == SBSD_OP_DEC_SKIP && r == 0) ? 4 : 3);
    end
    @(negedge clk_i);
    check("acc", accumulator_o, acc_m);
    check("flags", {28'h0, flags_o}, flg_m);
    check("mem", mem[adr], mexp);
    wb_xfer(1'b0, REG_ACC, 32'h0, rd, er);
    check("wb_acc", rd[7:0], acc_m);
    wb_xfer(1'b0, REG_STATUS, 32'h0, rd, er);
    check("wb_status", rd, (op == SBSD_OP_DEC_SKIP && r == 0) ? 4 : 0);
  endtask

  initial
  begin
    logic [31:0] rd;
    logic        er;
    logic [7:0]  adr;
    void'($urandom(32'ha7e9e158));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check("ready", op_ready_o, 1);
    check("acc_rst", accumulator_o, ACC_RST);
    check("flags_rst", {28'h0, flags_o}, FLAGS_RST);
    wb_xfer(1'b0, 4'h2, 32'h0, rd, er);
    check("wb_err", er, 1);
    for (int i = 0; i < 48; i++)
    begin
      adr = 8'($urandom);
      acc_m = $urandom & 255;
      flg_m = $urandom & 15;
      mem[adr] = 8'($urandom);
      if (i % 6 == 2)
        mem[adr] = 8'h01;
      if (i % 12 == 5)
        mem[adr] = 8'h00;
      if (i % 9 == 0)
        mem[adr] = 8'(acc_m - (flg_m[0] ? 0 : 1));
      wb_xfer(1'b1, REG_ACC, 32'(acc_m), rd, er);
      wb_xfer(1'b1, REG_FLAGS, 32'(flg_m), rd, er);
      wb_xfer(1'b0, REG_FLAGS, 32'h0, rd, er);
      check("wb_flags", rd[3:0], flg_m);
      exec_check(2'(i % 3), adr, i >= 46);
    end
    // the unused opcode must leave accumulator, flags and memory alone
    exec_check(SBSD_OP_NONE, adr, 1'b0);
    results();
  end
endmodule
`default_nettype wire
